// *** rtl/dpu_trigger_position_interface.sv ***
`timescale 1ns/10ps
`default_nettype none
module dpu_trigger_position_interface
	import trigger_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Sample blocks from the converter logic
	input wire logic adcBlockValid,
	input wire logic interleavedMode,
	input wire logic [MAX_SPB-1:0][SAMPLE_W-1:0] chanBlockA,
	input wire logic [MAX_SPB-1:0][SAMPLE_W-1:0] chanBlockB,
	input wire logic [EXT_COUNT-1:0][SAMPLE_W-1:0] extTriggerSample,
	// Trigger configuration
	input wire logic [3:0] triggerSource,
	input wire logic negativeSlope,
	input wire logic signed [SAMPLE_W-1:0] triggerLevel,
	// Trigger outputs to the processing units
	output logic triggerHitFlag,
	output logic [IDX_W-1:0] triggerSampleIndex,
	output logic [PHASE_W-1:0] triggerSubsamplePhase
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		block_phase_e blockPhase;
		logic [SAMPLE_W-1:0] prevSample;
		logic armed;
		logic pendingHit;
		logic [IDX_W-1:0] pendingIndex;
		logic [PHASE_W-1:0] pendingPhase;
		logic [5:0] holdoff;
		logic hitFlag;
		logic [IDX_W-1:0] sampleIndex;
		logic [PHASE_W-1:0] subPhase;
	} state_s;

	state_s st;
	state_s next_st;
	logic [MAX_SPB-1:0][SAMPLE_W-1:0] srcBlock;
	logic [IDX_W-1:0] samplesPerBlock;
	logic blockStart;
	logic accept;
	logic emit;
	logic found;
	logic [IDX_W-1:0] crossIndex;
	logic [PHASE_W-1:0] crossPhase;
	logic armedOut;

	// ---------------------------------------------------------------
	// Source selection
	// ---------------------------------------------------------------
	// An external input gives one value per block; spreading it over the
	// block lets the same finder interpolate between successive values
	always_comb begin
		srcBlock = '0;
		case (triggerSource)
			SRC_CHAN_A: srcBlock = chanBlockA;
			SRC_CHAN_B: srcBlock = chanBlockB;
			default: begin
				if (triggerSource >= SRC_EXT_FIRST &&
					triggerSource <= SRC_EXT_BACKPLANE) begin
					for (int i = 0; i < MAX_SPB; i++) begin
						srcBlock[i] = extTriggerSample[
							2'(triggerSource - SRC_EXT_FIRST)];
					end
				end
			end
		endcase
	end

	// Block size follows the sampling mode
	assign samplesPerBlock = interleavedMode ? SPB_INTERLEAVED :
		SPB_NORMAL;

	// Each block is judged once, on its first valid clock
	assign blockStart = adcBlockValid && st.blockPhase == BLK_FIRST;

	// ---------------------------------------------------------------
	// Crossing search
	// ---------------------------------------------------------------
	crossing_finder u_finder (
		.samples(srcBlock),
		.prevSample(st.prevSample),
		.samplesPerBlock(samplesPerBlock),
		.level(triggerLevel),
		.negativeSlope(negativeSlope),
		.armedIn(st.armed),
		.found(found),
		.crossIndex(crossIndex),
		.crossPhase(crossPhase),
		.armedOut(armedOut)
	);

	// A new trigger is taken only once the holdoff has run out and no
	// earlier one still waits for its block
	assign accept = blockStart && found && st.holdoff == RST_HOLDOFF &&
		!st.pendingHit && triggerSource != SRC_NONE;
	// Emission waits for the start of the following block
	assign emit = blockStart && st.pendingHit &&
		triggerSource != SRC_NONE;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.hitFlag = emit;
		if (adcBlockValid) begin
			next_st.blockPhase = (st.blockPhase == BLK_FIRST) ?
				BLK_SECOND : BLK_FIRST;
		end
		if (blockStart) begin
			next_st.prevSample = srcBlock[5'(samplesPerBlock - 7'h01)];
			next_st.armed = armedOut;
		end
		if (triggerSource == SRC_NONE) begin
			next_st.pendingHit = 1'b0;
		end else if (emit) begin
			next_st.pendingHit = 1'b0;
		end else if (accept) begin
			next_st.pendingHit = 1'b1;
			next_st.pendingIndex = crossIndex;
			next_st.pendingPhase = crossPhase;
		end
		if (emit) begin
			next_st.sampleIndex = st.pendingIndex;
			next_st.subPhase = st.pendingPhase;
			next_st.holdoff = HOLDOFF_CYCLES;
		end else if (st.holdoff != RST_HOLDOFF) begin
			next_st.holdoff = st.holdoff - 6'h01;
		end
	end

	// Register stage; reset opens the holdoff at once
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '{blockPhase: BLK_FIRST, prevSample: '0, armed: 1'b0,
				pendingHit: 1'b0, pendingIndex: RST_INDEX,
				pendingPhase: RST_PHASE, holdoff: RST_HOLDOFF,
				hitFlag: 1'b0, sampleIndex: RST_INDEX,
				subPhase: RST_PHASE};
		end else begin
			st <= next_st;
		end
	end

	// One flop set fans out to every unit, so all see the same edge
	assign triggerHitFlag = st.hitFlag;
	assign triggerSampleIndex = st.sampleIndex;
	assign triggerSubsamplePhase = st.subPhase;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [5:0] sinceHit;

	// Cycles since the last hit, saturating
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sinceHit <= SINCE_HIT_MAX;
		end else if (triggerHitFlag) begin
			sinceHit <= 6'h01;
		end else if (sinceHit != SINCE_HIT_MAX) begin
			sinceHit <= sinceHit + 6'h01;
		end
	end

	property p_hit_one_cycle;
		@(posedge clk) disable iff (sys_rst)
		triggerHitFlag |=> !triggerHitFlag;
	endproperty
	a_hit_one_cycle: assert property (p_hit_one_cycle)
		else $error("hit flag longer than one cycle");

	property p_holdoff_gap;
		@(posedge clk) disable iff (sys_rst)
		triggerHitFlag |-> sinceHit > HOLDOFF_CYCLES;
	endproperty
	a_holdoff_gap: assert property (p_holdoff_gap)
		else $error("hits closer than holdoff");

	property p_none_quiet;
		@(posedge clk) disable iff (sys_rst)
		triggerSource == SRC_NONE |=> !triggerHitFlag;
	endproperty
	a_none_quiet: assert property (p_none_quiet)
		else $error("hit with source none");

	property p_hold_values;
		@(posedge clk) disable iff (sys_rst)
		!triggerHitFlag |-> $stable(triggerSampleIndex) &&
			$stable(triggerSubsamplePhase);
	endproperty
	a_hold_values: assert property (p_hold_values)
		else $error("position changed without hit");

	property p_next_block;
		@(posedge clk) disable iff (sys_rst)
		accept ##1 adcBlockValid ##1 (adcBlockValid &&
			triggerSource != SRC_NONE) |=> triggerHitFlag ##0
			triggerSampleIndex == $past(crossIndex, 3);
	endproperty
	a_next_block: assert property (p_next_block)
		else $error("hit not in following block");

	property p_hit_on_block_start;
		@(posedge clk) disable iff (sys_rst)
		triggerHitFlag |-> $past(blockStart);
	endproperty
	a_hit_on_block_start: assert property (p_hit_on_block_start)
		else $error("hit off block boundary");

	property p_index_range;
		@(posedge clk) disable iff (sys_rst)
		accept |-> crossIndex < samplesPerBlock;
	endproperty
	a_index_range: assert property (p_index_range)
		else $error("sample index out of block");

	property p_no_accept_in_holdoff;
		@(posedge clk) disable iff (sys_rst)
		triggerHitFlag |-> !accept [*8];
	endproperty
	a_no_accept_in_holdoff: assert property (p_no_accept_in_holdoff)
		else $error("trigger accepted during holdoff");

	property p_block_alternate;
		@(posedge clk) disable iff (sys_rst)
		blockStart |=> st.blockPhase == BLK_SECOND;
	endproperty
	a_block_alternate: assert property (p_block_alternate)
		else $error("block phase did not advance");

	c_hit: cover property (@(posedge clk) disable iff (sys_rst)
		triggerHitFlag);
	c_exact: cover property (@(posedge clk) disable iff (sys_rst)
		triggerHitFlag && triggerSubsamplePhase == RST_PHASE);
	c_blocked: cover property (@(posedge clk) disable iff (sys_rst)
		blockStart && found && st.holdoff != RST_HOLDOFF);

endmodule : dpu_trigger_position_interface
`default_nettype wire

// *** rtl/trigger_pkg.sv ***
package trigger_pkg;

	// ---------------------------------------------------------------
	// Widths
	// ---------------------------------------------------------------
	localparam int SAMPLE_W = 16;
	localparam int IDX_W = 7;
	localparam int PHASE_W = 32;
	localparam int MAX_SPB = 32;
	localparam int EXT_COUNT = 4;

	// ---------------------------------------------------------------
	// Block geometry and clock relation
	// ---------------------------------------------------------------
	localparam logic [IDX_W-1:0] SPB_NORMAL = 7'h10;
	localparam logic [IDX_W-1:0] SPB_INTERLEAVED = 7'h20;
	localparam int CLK_PERIOD_PS = 20000;
	// One block spans two clocks, so a sample lasts 2/spb of a clock
	localparam int SAMPLE_PERIOD_NORMAL_PS = CLK_PERIOD_PS * 2 / 16;
	localparam int SAMPLE_PERIOD_INTERLEAVED_PS = CLK_PERIOD_PS * 2 / 32;

	// ---------------------------------------------------------------
	// Level crossing and holdoff
	// ---------------------------------------------------------------
	localparam int FULL_SCALE_COUNTS = 65536;
	localparam int HYST_PERCENT = 5;
	localparam logic signed [17:0] HYST_COUNTS =
		18'(FULL_SCALE_COUNTS * HYST_PERCENT / 100);
	localparam logic [5:0] HOLDOFF_CYCLES = 6'h28;
	localparam logic [5:0] SINCE_HIT_MAX = 6'h3f;

	// ---------------------------------------------------------------
	// Trigger source codes
	// ---------------------------------------------------------------
	localparam logic [3:0] SRC_NONE = 4'h0;
	localparam logic [3:0] SRC_CHAN_A = 4'h1;
	localparam logic [3:0] SRC_CHAN_B = 4'h2;
	localparam logic [3:0] SRC_EXT_FIRST = 4'h3;
	localparam logic [3:0] SRC_EXT_BACKPLANE = 4'h6;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [IDX_W-1:0] RST_INDEX = 7'h00;
	localparam logic [PHASE_W-1:0] RST_PHASE = 32'h0000_0000;
	localparam logic [5:0] RST_HOLDOFF = 6'h00;

	typedef enum logic {
		BLK_FIRST,
		BLK_SECOND
	} block_phase_e;

	// Restoring division, num < den, yields a pure fraction
	function automatic logic [PHASE_W-1:0] phase_fraction(
		input logic [17:0] num,
		input logic [17:0] den
	);
		logic [18:0] rem;
		logic [PHASE_W-1:0] q;
		rem = {1'b0, num};
		q = '0;
		for (int b = PHASE_W - 1; b >= 0; b--) begin
			rem = {rem[17:0], 1'b0};
			if (rem >= {1'b0, den}) begin
				rem = rem - {1'b0, den};
				q[b] = 1'b1;
			end
		end
		return q;
	endfunction : phase_fraction

endpackage : trigger_pkg

// *** rtl/crossing_finder.sv ***
`timescale 1ns/10ps
`default_nettype none
module crossing_finder
	import trigger_pkg::*;
(
	// Sample block
	input wire logic [MAX_SPB-1:0][SAMPLE_W-1:0] samples,
	input wire logic [SAMPLE_W-1:0] prevSample,
	input wire logic [IDX_W-1:0] samplesPerBlock,
	// Configuration
	input wire logic signed [SAMPLE_W-1:0] level,
	input wire logic negativeSlope,
	input wire logic armedIn,
	// Result
	output logic found,
	output logic [IDX_W-1:0] crossIndex,
	output logic [PHASE_W-1:0] crossPhase,
	output logic armedOut
);

	// ---------------------------------------------------------------
	// Sequential scan of the block for the first armed crossing
	// ---------------------------------------------------------------
	// Falling edges are found by negating everything, so one comparator
	// chain serves both slopes
	always_comb begin
		logic signed [17:0] prev;
		logic signed [17:0] cur;
		logic signed [17:0] lvl;
		logic arm;
		prev = '0;
		cur = '0;
		lvl = negativeSlope ? -18'(level) : 18'(level);
		arm = armedIn;
		found = 1'b0;
		crossIndex = '0;
		crossPhase = '0;
		prev = negativeSlope ? -18'(signed'(prevSample)) :
			18'(signed'(prevSample));
		for (int i = 0; i < MAX_SPB; i++) begin
			if (i < int'(samplesPerBlock)) begin
				cur = negativeSlope ? -18'(signed'(samples[i])) :
					18'(signed'(samples[i]));
				if (!found && arm && prev < lvl && cur >= lvl) begin
					found = 1'b1;
					arm = 1'b0;
					if (cur == lvl) begin
						crossIndex = 7'(i);
						crossPhase = '0;
					end else begin
						// Sample before the crossing; previous block's last
						crossIndex = (i == 0) ?
							7'(samplesPerBlock - 7'h01) : 7'(i - 1);
						crossPhase = phase_fraction(
							18'(cur - lvl), 18'(cur - prev));
					end
				end else if (cur <= lvl - HYST_COUNTS) begin
					arm = 1'b1;
				end
				prev = cur;
			end
		end
		armedOut = arm;
	end

endmodule : crossing_finder
`default_nettype wire

// *** verif/trigger_sink_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// User processing logic that consumes the trigger outputs
// ---------------------------------------------------------------
module trigger_sink_model
	import trigger_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Trigger outputs of the block
	input wire logic hitFlag,
	input wire logic [IDX_W-1:0] sampleIndex,
	// Observations
	output logic [15:0] hitCount,
	output logic [IDX_W-1:0] lastIndex
);
	// Counts flag-high cycles, so a stretched pulse shows as extra hits
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hitCount <= 16'h0000;
			lastIndex <= 7'h00;
		end else if (hitFlag) begin
			hitCount <= hitCount + 16'h0001;
			lastIndex <= sampleIndex;
		end
	end
endmodule : trigger_sink_model
`default_nettype wire

// *** verif/test_dpu_trigger_position_interface.sv ***
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
	failures++; $display("FAIL at %0t: got %0h expected %0h", \
	$time, got, exp); end end
module test_dpu_trigger_position_interface
	import trigger_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam logic [PHASE_W-1:0] HALF_UP = 32'hc000_0000;
	// Straddling crossing from -4000 to 300 around level zero
	localparam logic [PHASE_W-1:0] STRAD = 32'((64'd300 << 32) / 64'd4300);
	logic clk;
	logic sys_rst;
	logic adcBlockValid;
	logic interleavedMode;
	logic [MAX_SPB-1:0][SAMPLE_W-1:0] chanBlockA;
	logic [MAX_SPB-1:0][SAMPLE_W-1:0] chanBlockB;
	logic [EXT_COUNT-1:0][SAMPLE_W-1:0] extTriggerSample;
	logic [3:0] triggerSource;
	logic negativeSlope;
	logic signed [SAMPLE_W-1:0] triggerLevel;
	logic triggerHitFlag;
	logic [IDX_W-1:0] triggerSampleIndex;
	logic [PHASE_W-1:0] triggerSubsamplePhase;
	logic [15:0] hitCount;
	logic [IDX_W-1:0] lastIndex;
	int failures;
	int checks_done;
	int cycles = 0;

	// ---------------------------------------------------------------
	// Instances
	// ---------------------------------------------------------------
	dpu_trigger_position_interface dpu_trigger_position_interface_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.adcBlockValid(adcBlockValid),
		.interleavedMode(interleavedMode),
		.chanBlockA(chanBlockA),
		.chanBlockB(chanBlockB),
		.extTriggerSample(extTriggerSample),
		.triggerSource(triggerSource),
		.negativeSlope(negativeSlope),
		.triggerLevel(triggerLevel),
		.triggerHitFlag(triggerHitFlag),
		.triggerSampleIndex(triggerSampleIndex),
		.triggerSubsamplePhase(triggerSubsamplePhase)
	);
	trigger_sink_model trigger_sink_model_inst (
		.clk(clk),
		.sys_rst(sys_rst),
		.hitFlag(triggerHitFlag),
		.sampleIndex(triggerSampleIndex),
		.hitCount(hitCount),
		.lastIndex(lastIndex)
	);

	// ---------------------------------------------------------------
	// Clock and hang guard
	// ---------------------------------------------------------------
	always #10 clk = ~clk;

	// About 700 cycles expected; the ceiling leaves ample margin
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			$display("FAIL at %0t: got %0h expected %0h", $time, cycles, 0);
			finish_test();
		end
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic finish_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test

	// One block held for two clocks; samples below i are lo, rest hi
	task automatic blk(input int lo, input int hi, input int i);
		logic [MAX_SPB-1:0][SAMPLE_W-1:0] b;
		for (int k = 0; k < MAX_SPB; k++) begin
			b[k] = (k < i) ? 16'(lo) : 16'(hi);
		end
		chanBlockA <= b;
		chanBlockB <= b;
		for (int k = 0; k < EXT_COUNT; k++) begin
			extTriggerSample[k] <= 16'(hi);
		end
		repeat (2) @(posedge clk);
	endtask : blk

	// Arm, cross, then look while the block after the crossing is held
	task automatic trig(input string name, input int lo, input int hi,
		input int i, input logic e, input logic [IDX_W-1:0] ei,
		input logic [PHASE_W-1:0] ep, input bit pad);
		int arm;
		logic [15:0] n;
		arm = negativeSlope ? 4000 : -4000;
		blk(arm, arm, 0);
		n = hitCount;
		blk(lo, hi, i);
		// The hit stands for one clock only, launched by the next block
		// start, so it is looked at mid-cycle in that block's second clock
		fork
			blk(arm, arm, 0);
			begin
				repeat (2) @(negedge clk);
				`CHK(triggerHitFlag, e)
				`CHK(triggerSampleIndex, ei)
				`CHK(triggerSubsamplePhase, ep)
			end
		join
		// Padding outlasts the holdoff before the next scenario
		if (pad) begin
			repeat (22) blk(arm, arm, 0);
			`CHK(hitCount, n + 16'(e))
		end
		$display("test %0s done", name);
	endtask : trig

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		sys_rst = 1'b1;
		adcBlockValid = 1'b0;
		interleavedMode = 1'b0;
		chanBlockA = '0;
		chanBlockB = '0;
		extTriggerSample = '0;
		triggerSource = SRC_CHAN_A;
		negativeSlope = 1'b0;
		triggerLevel = 16'sh0000;
		failures = 0;
		checks_done = 0;
		// Outputs must read zero while reset is still held
		repeat (19) @(posedge clk);
		@(negedge clk);
		`CHK(triggerHitFlag, 1'b0)
		`CHK(triggerSampleIndex, 7'h00)
		`CHK(triggerSubsamplePhase, 32'h0000_0000)
		@(posedge clk);
		sys_rst <= 1'b0;
		adcBlockValid <= 1'b1;
		trig("walk", -100, 300, 3, 1'b1, 7'h02, HALF_UP, 1);
		trig("exact", -100, 0, 5, 1'b1, 7'h05, 32'h0, 1);
		negativeSlope <= 1'b1;
		triggerSource <= SRC_CHAN_B;
		// One idle block, so the arming level follows the new slope
		repeat (2) @(posedge clk);
		trig("falling", 100, -300, 7, 1'b1, 7'h06, HALF_UP, 1);
		negativeSlope <= 1'b0;
		repeat (2) @(posedge clk);
		for (int s = 1; s <= 6; s++) begin
			triggerSource <= 4'(s);
			trig("source", 300, 300, 0, 1'b1, 7'h0f, STRAD, 1);
		end
		interleavedMode <= 1'b1;
		triggerSource <= SRC_CHAN_A;
		trig("interleaved", -100, 300, 20, 1'b1, 7'h13, HALF_UP, 1);
		trig("straddle", 300, 300, 0, 1'b1, 7'h1f, STRAD, 1);
		// A raised level moves the interpolated point to mid-interval
		triggerLevel <= 16'sh0064;
		trig("level", -100, 300, 3, 1'b1, 7'h02, 32'h8000_0000, 1);
		triggerLevel <= 16'sh0000;
		trig("holdoff", -100, 300, 9, 1'b1, 7'h08, HALF_UP, 0);
		trig("ignored", -100, 300, 4, 1'b0, 7'h08, HALF_UP, 1);
		`CHK(lastIndex, 7'h08)
		triggerSource <= SRC_NONE;
		trig("none", -100, 300, 3, 1'b0, 7'h08, HALF_UP, 1);
		finish_test();
	end
endmodule : test_dpu_trigger_position_interface
`default_nettype wire
